// File: include/otp_params.svh
// Constants for the over-temperature pin configuration bank.
// Assumes byte addressing on a 32-bit Wishbone bus, one register per word.
`ifndef OTP_PARAMS_SVH
`define OTP_PARAMS_SVH

// Register indices; byte address is four times the index
`define OTP_IDX_LOCK        8'h40
`define OTP_IDX_MAXDUTY0    8'h38
`define OTP_IDX_ENABLES     8'h7C
`define OTP_IDX_PINCFG      8'h7D
`define OTP_IDX_TEST_A      8'h7E
`define OTP_IDX_TEST_B      8'h7F
`define OTP_IDX_TEST_C      8'h80
`define OTP_IDX_LIMIT0      8'h90
`define OTP_IDX_STATUS      8'h94
`define OTP_IDX_MASK        8'h95

// Reset values
`define OTP_RST_ENABLES     8'h00
`define OTP_RST_PINCFG      8'h00
`define OTP_RST_TEST_A      8'h00
`define OTP_RST_TEST_B      8'h00
`define OTP_RST_TEST_C      8'h10
`define OTP_RST_LIMIT       8'h00
`define OTP_RST_MAXDUTY     8'hFF

// Writable bits of the two lockable registers
`define OTP_WMASK_ENABLES   8'hE1
`define OTP_WMASK_PINCFG    8'h3F
`define OTP_WMASK_PINCFG_NL 8'h2F

// Field positions in the enables register and the lock register
`define OTP_EN_FMT_BIT      0
`define OTP_EN_REMOTE1_BIT  5
`define OTP_EN_LOCAL_BIT    6
`define OTP_EN_REMOTE2_BIT  7
`define OTP_LOCK_BIT        0

// Shared pin function codes
`define OTP_FN_FAN4_TACH    2'h0
`define OTP_FN_OVERTEMP     2'h1
`define OTP_FN_SMB_ALERT    2'h2
`define OTP_FN_GPIO         2'h3

// Limit codes that switch a channel off, and full fan duty
`define OTP_OFF64_DISABLED  8'h00
`define OTP_TWOS_DISABLED   8'h80
`define OTP_FULL_DUTY       8'hFF

// Latch channel masks: bit 0 local, bit 1 remote 1, bit 2 remote 2
`define OTP_LATCH_R2        3'h4
`define OTP_LATCH_R1_R2     3'h6

`endif

// File: include/otp_pkg.sv
// Types shared by the over-temperature configuration bank.
// Assumes otp_params.svh supplies the numeric constants.
package otp_pkg;

  // Configuration register layout for the shared pin and fan action
  typedef struct packed {
    logic [1:0] unused;
    logic       attn_bypass;
    logic       latch_sel;
    logic       fan_target;
    logic       feature_off;
    logic [1:0] fn_sel;
  } otp_pin_cfg_t;

  // Event bits of the status and mask registers
  typedef struct packed {
    logic [3:0] unused;
    logic       ext_pin;
    logic [2:0] chan_hit;
  } otp_events_t;

endpackage

// File: rtl/otp_fan_mux.sv
// Fan duty override applied while over-temperature is active.
// Assumes duty_in comes from the fan control loop in this clock domain.
`timescale 1ns/10ps
`include "otp_params.svh"
module otp_fan_mux #(
  parameter int NFAN = 3
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_sync_n,
  // Control
  input  wire logic              active,
  input  wire logic              to_max,
  // Duty values
  input  wire logic [NFAN*8-1:0] duty_in,
  input  wire logic [NFAN*8-1:0] max_duty,
  output logic      [NFAN*8-1:0] duty_out
);

  // One registered selector per fan
  genvar g;
  generate
    for (g = 0; g < NFAN; g++) begin : g_fan
      always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          duty_out[g*8 +: 8] <= 8'h00;
        end else if (active && !to_max) begin
          duty_out[g*8 +: 8] <= `OTP_FULL_DUTY;
        end else if (active) begin
          duty_out[g*8 +: 8] <= max_duty[g*8 +: 8];
        end else begin
          duty_out[g*8 +: 8] <= duty_in[g*8 +: 8];
        end
      end

      AST_FULL_SPEED: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        active && !to_max |=> duty_out[g*8 +: 8] == 8'hFF)
        else $error("fan not at full duty while over-temperature");

      AST_MAX_SPEED: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        active && to_max |=> duty_out[g*8 +: 8] == $past(max_duty[g*8 +: 8]))
        else $error("fan not at programmed maximum duty");
    end
  endgenerate

endmodule

// File: rtl/otp_limit_cmp.sv
// Limit comparator for one temperature channel.
// Assumes reading and limit share the encoding chosen by twos_mode.
`timescale 1ns/10ps
`include "otp_params.svh"
module otp_limit_cmp (
  // Encoding and enable
  input  wire logic       twos_mode,
  input  wire logic       enable,
  // Values
  input  wire logic [7:0] reading,
  input  wire logic [7:0] limit,
  // Results
  output logic            disabled,
  output logic            hit
);

  // Map either encoding onto an unsigned scale so one compare serves both
  function automatic logic [7:0] ordered(input logic [7:0] v,
                                         input logic       twos);
    ordered = twos ? {~v[7], v[6:0]} : v;
  endfunction

  // Lowest code of each encoding switches the channel off
  assign disabled = twos_mode ? (limit == `OTP_TWOS_DISABLED)
                              : (limit == `OTP_OFF64_DISABLED);

  // Encoding follows the format bit at once, no resampling
  assign hit = enable && !disabled &&
               (ordered(reading, twos_mode) > ordered(limit, twos_mode));

endmodule

// File: rtl/otp_regs.sv
// Over-temperature pin configuration bank with Wishbone slave.
// Assumes readings and fan duties arrive synchronous to mclk, and the
// over-temperature pin is open drain, resolved outside from its enable.
//
// Notes on behaviour
// - Local enable set applies the limit to the local channel and lets it drive the pin, clear leaves the pin a timer input.
// - Remote 2 enable set compares remote 2 against its limit and lets it drive the pin, clear leaves a timer input.
// - In offset-64 format a limit of code 0x00 (minus 64 degrees) switches that channel off.
// - In two's complement format a limit of code 0x80 (minus 128 degrees) switches that channel off.
// - After the lock bit is set, writes to the enables and pin configuration registers are ignored.
// - The two-bit select routes the shared pin: 00 fan 4 tach, 01 over-temperature, 10 bus alert, 11 GPIO.
// - The feature-off bit suppresses all over-temperature action whatever the channel enables say.
// - With fan target 0 an exceeded enabled limit forces every fan to full duty.
// - With fan target 1 an exceeded enabled limit drives each fan to its own maximum duty register.
// - On the latching variant the latch select picks remote 2 alone (0) or remotes 1 and 2 (1).
// - The attenuator bypass bit switches the core voltage channel to its 0 V to 2.2965 V scale.
// - The three test registers read their fixed values and ignore writes.
// - The format bit selects two's complement or offset-64 for all temperatures, taking effect at once.
// - Remote 1 enable set lets remote 1 drive the pin, clear leaves a timer input.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`include "otp_params.svh"
module otp_regs #(
  parameter int NFAN      = 3,
  parameter bit HAS_LATCH = 1'b1
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [9:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Temperature readings
  input  wire logic [7:0]        temp_local,
  input  wire logic [7:0]        temp_remote1,
  input  wire logic [7:0]        temp_remote2,
  // Fan duties
  input  wire logic [NFAN*8-1:0] fan_duty_in,
  output logic      [NFAN*8-1:0] fan_duty_out,
  // Over-temperature pin
  input  wire logic              overtemp_pin_in,
  output logic                   overtemp_pin_out,
  output logic                   overtemp_pin_oe_n,
  output logic                   overtemp_timer_active,
  // Configuration outputs
  output logic      [1:0]        shared_pin_function_select,
  output logic                   core_voltage_attenuator_bypass,
  output logic                   temperature_format_select,
  // Interrupt
  output logic                   irq
);

  // Reset synchroniser
  logic       rst_meta_n;
  logic       rst_sync_n;

  // Registers
  logic [7:0]        enables;
  otp_pkg::otp_pin_cfg_t pin_cfg;
  logic              lock;
  logic [7:0]        limit [3];
  logic [NFAN*8-1:0] max_duty;
  otp_pkg::otp_events_t status;
  otp_pkg::otp_events_t mask;

  // Bus decode
  logic [7:0] idx;
  logic       req;
  logic       wr;
  logic [7:0] wdat;
  logic [7:0] next_rdat;

  // Over-temperature logic
  logic [2:0] chan_en;
  logic [2:0] hit;
  logic [2:0] chan_off;
  logic [2:0] latched;
  logic [2:0] latch_mask;
  logic       ext_event;
  logic       overtemp_active;
  logic       pin_is_overtemp;
  otp_pkg::otp_events_t next_events;

  // Release reset through two flops so removal is clean
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Index match, used by every register write
  function automatic logic at(input logic [7:0] a, input logic [7:0] b);
    at = (a == b);
  endfunction

  // Request qualifiers; only byte lane 0 carries data
  assign idx  = wb_adr_i[9:2];
  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr   = req && wb_we_i && wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];

  // Ack one cycle after the request; dropped the cycle after
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Lock bit is set-only; nothing short of reset unlocks
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lock <= 1'b0;
    end else if (wr && at(idx, `OTP_IDX_LOCK) && wdat[`OTP_LOCK_BIT]) begin
      lock <= 1'b1;
    end
  end

  // Lockable configuration; unwritable bits stay zero
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      enables <= `OTP_RST_ENABLES;
      pin_cfg <= `OTP_RST_PINCFG;
    end else if (wr && !lock) begin
      if (at(idx, `OTP_IDX_ENABLES)) begin
        enables <= wdat & `OTP_WMASK_ENABLES;
      end
      if (at(idx, `OTP_IDX_PINCFG)) begin
        // Latch select only exists on the latching variant
        pin_cfg <= wdat & (HAS_LATCH ? `OTP_WMASK_PINCFG
                                     : `OTP_WMASK_PINCFG_NL);
      end
    end
  end

  // Limits and per-fan maximum duties
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 3; i++) begin
        limit[i] <= `OTP_RST_LIMIT;
      end
      max_duty <= {NFAN{`OTP_RST_MAXDUTY}};
    end else if (wr) begin
      for (int i = 0; i < 3; i++) begin
        if (at(idx, `OTP_IDX_LIMIT0 + 8'(i))) begin
          limit[i] <= wdat;
        end
      end
      for (int i = 0; i < NFAN; i++) begin
        if (at(idx, `OTP_IDX_MAXDUTY0 + 8'(i))) begin
          max_duty[i*8 +: 8] <= wdat;
        end
      end
    end
  end

  // Per-channel enables: 0 local, 1 remote 1, 2 remote 2
  assign chan_en = {enables[`OTP_EN_REMOTE2_BIT],
                    enables[`OTP_EN_REMOTE1_BIT],
                    enables[`OTP_EN_LOCAL_BIT]};

  // One comparator per channel
  otp_limit_cmp u_cmp_local (
    .twos_mode (enables[`OTP_EN_FMT_BIT]),
    .enable    (chan_en[0]),
    .reading   (temp_local),
    .limit     (limit[0]),
    .disabled  (chan_off[0]),
    .hit       (hit[0])
  );

  otp_limit_cmp u_cmp_remote1 (
    .twos_mode (enables[`OTP_EN_FMT_BIT]),
    .enable    (chan_en[1]),
    .reading   (temp_remote1),
    .limit     (limit[1]),
    .disabled  (chan_off[1]),
    .hit       (hit[1])
  );

  otp_limit_cmp u_cmp_remote2 (
    .twos_mode (enables[`OTP_EN_FMT_BIT]),
    .enable    (chan_en[2]),
    .reading   (temp_remote2),
    .limit     (limit[2]),
    .disabled  (chan_off[2]),
    .hit       (hit[2])
  );

  // Which channels latch; none on the plain variant
  assign latch_mask = !HAS_LATCH ? 3'h0 :
                      pin_cfg.latch_sel ? `OTP_LATCH_R1_R2
                                        : `OTP_LATCH_R2;

  // A latch holds until its channel is disabled or deselected, or software
  // clears its status bit with the channel back under limit; a fresh hit wins over that clear
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      latched <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (hit[i] && latch_mask[i]) begin
          latched[i] <= 1'b1;
        end else if (!latch_mask[i] || !chan_en[i] ||
                     (wr && at(idx, `OTP_IDX_STATUS) && wdat[i])) begin
          latched[i] <= 1'b0;
        end
      end
    end
  end

  // Feature-off overrides every channel enable
  assign overtemp_active = !pin_cfg.feature_off &&
                           (|hit || |latched);

  // Pin only serves this block when routed here
  assign pin_is_overtemp = (pin_cfg.fn_sel == `OTP_FN_OVERTEMP);

  // Open drain: drive low, enable low while driving
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      overtemp_pin_oe_n <= 1'b1;
    end else begin
      overtemp_pin_oe_n <= !(overtemp_active && pin_is_overtemp);
    end
  end
  assign overtemp_pin_out = 1'b0;

  // Pin pulled low by someone else acts as the timer input
  assign ext_event = pin_is_overtemp && overtemp_pin_oe_n &&
                     !overtemp_pin_in;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      overtemp_timer_active <= 1'b0;
    end else begin
      overtemp_timer_active <= ext_event;
    end
  end

  // Configuration fields out, registered
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      shared_pin_function_select     <= `OTP_FN_FAN4_TACH;
      core_voltage_attenuator_bypass <= 1'b0;
      temperature_format_select      <= 1'b0;
    end else begin
      shared_pin_function_select     <= pin_cfg.fn_sel;
      core_voltage_attenuator_bypass <= pin_cfg.attn_bypass;
      temperature_format_select      <= enables[`OTP_EN_FMT_BIT];
    end
  end

  // Fan override, registered per fan
  otp_fan_mux #(
    .NFAN (NFAN)
  ) u_fan (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_n),
    .active     (overtemp_active),
    .to_max     (pin_cfg.fan_target),
    .duty_in    (fan_duty_in),
    .max_duty   (max_duty),
    .duty_out   (fan_duty_out)
  );

  // Sticky events; set wins over a write-one clear
  always_comb begin
    next_events          = '0;
    next_events.chan_hit = pin_cfg.feature_off ? 3'h0 : hit;
    next_events.ext_pin  = ext_event;
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status <= '0;
    end else if (wr && at(idx, `OTP_IDX_STATUS)) begin
      status <= (status & ~otp_pkg::otp_events_t'(wdat)) | next_events;
    end else begin
      status <= status | next_events;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask <= '0;
    end else if (wr && at(idx, `OTP_IDX_MASK)) begin
      mask <= otp_pkg::otp_events_t'(wdat & 8'h0F);
    end
  end

  assign irq = |(status & mask);

  // Read multiplexer; unmapped indices answer zero
  always_comb begin
    next_rdat = 8'h00;
    case (idx)
      `OTP_IDX_LOCK:    next_rdat = {7'h00, lock};
      `OTP_IDX_ENABLES: next_rdat = enables;
      `OTP_IDX_PINCFG:  next_rdat = pin_cfg;
      `OTP_IDX_TEST_A:  next_rdat = `OTP_RST_TEST_A;
      `OTP_IDX_TEST_B:  next_rdat = `OTP_RST_TEST_B;
      `OTP_IDX_TEST_C:  next_rdat = `OTP_RST_TEST_C;
      `OTP_IDX_STATUS:  next_rdat = status;
      `OTP_IDX_MASK:    next_rdat = mask;
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (at(idx, `OTP_IDX_LIMIT0 + 8'(i))) begin
            next_rdat = limit[i];
          end
        end
        for (int i = 0; i < NFAN; i++) begin
          if (at(idx, `OTP_IDX_MAXDUTY0 + 8'(i))) begin
            next_rdat = max_duty[i*8 +: 8];
          end
        end
      end
    endcase
  end

  // Read data registered with ack; upper bits read zero
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      wb_dat_o <= {24'h00_0000, next_rdat};
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  sequence seq_locked_cfg_write;
    lock && wr && (at(idx, `OTP_IDX_PINCFG) || at(idx, `OTP_IDX_ENABLES));
  endsequence

  AST_LOCK_HOLD: assert property (
    seq_locked_cfg_write |=> $stable(pin_cfg) && $stable(enables))
    else $error("locked configuration changed on write");

  AST_LOCAL_OFF: assert property (
    !enables[`OTP_EN_LOCAL_BIT] |-> !hit[0])
    else $error("local channel hit while disabled");

  AST_REMOTE2_OFF: assert property (
    !enables[`OTP_EN_REMOTE2_BIT] |-> !hit[2])
    else $error("remote 2 hit while disabled");

  AST_REMOTE1_OFF: assert property (
    !enables[`OTP_EN_REMOTE1_BIT] |-> !hit[1])
    else $error("remote 1 hit while disabled");

  AST_OFF64_LIMIT: assert property (
    !enables[`OTP_EN_FMT_BIT] && limit[2] == 8'h00 |-> !hit[2])
    else $error("offset-64 disabled limit still compares");

  AST_TWOS_LIMIT: assert property (
    enables[`OTP_EN_FMT_BIT] && limit[1] == 8'h80 |-> chan_off[1])
    else $error("two's complement disabled limit not seen");

  AST_FEATURE_OFF: assert property (
    pin_cfg.feature_off [*2] |-> overtemp_pin_oe_n)
    else $error("pin driven with feature off");

  AST_PIN_DRIVE: assert property (
    overtemp_active && pin_is_overtemp |=> !overtemp_pin_oe_n)
    else $error("pin not driven while over temperature");

  AST_FN_SELECT: assert property (
    ##1 shared_pin_function_select == $past(pin_cfg.fn_sel))
    else $error("shared pin function does not follow select");

  AST_TEST_READ: assert property (
    req && at(idx, `OTP_IDX_TEST_C) |=> wb_ack_o && wb_dat_o == 32'h10)
    else $error("test register read wrong");

endmodule

// File: tb/tb_otp_regs.sv
// Self-checking bench for the over-temperature pin configuration bank.
// Assumes otp_regs with NFAN=3 and the latching variant, byte addressing.
`timescale 1ns/10ps
`include "otp_params.svh"
module tb_otp_regs;
  // Clock, reset and bus
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  // Readings, fans, pin
  logic [7:0]  temp_local = 8'h00;
  logic [7:0]  temp_remote1 = 8'h00;
  logic [7:0]  temp_remote2 = 8'h00;
  logic [23:0] fan_duty_in = 24'h30_2010;
  logic [23:0] fan_duty_out;
  logic        pin_level;
  logic        oe_n;
  logic        irq;
  logic [1:0]  fn_sel;
  logic        bypass;
  logic        fmt;
  logic        ext_pull = 1'b0;
  logic        timer;
  logic        pin_out;
  int          err_total = 0;
  int          checked = 0;

  always #2 mclk = ~mclk;
  // Open-drain pin with pull-up: low while the device or the bench pulls
  assign pin_level = (oe_n && !ext_pull) ? 1'b1 : 1'b0;

  otp_regs i_otp_regs (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .temp_local(temp_local), .temp_remote1(temp_remote1),
    .temp_remote2(temp_remote2), .fan_duty_in(fan_duty_in),
    .fan_duty_out(fan_duty_out), .overtemp_pin_in(pin_level),
    .overtemp_pin_out(pin_out), .overtemp_pin_oe_n(oe_n),
    .overtemp_timer_active(timer), .shared_pin_function_select(fn_sel),
    .core_voltage_attenuator_bypass(bypass),
    .temperature_format_select(fmt), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] idx,
                    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h00_0000, wd};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("MISMATCH %0t no acknowledge", $time);
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    wb(1'b1, idx, wd, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    wb(1'b0, idx, 8'h00, d);
    chk(d, exp);
  endtask

  task automatic temps(input logic [7:0] l, r1, r2);
    @(posedge mclk);
    temp_local   <= l;
    temp_remote1 <= r1;
    temp_remote2 <= r2;
  endtask

  // Pin and fan outputs settle one cycle after their cause
  task automatic pin(input logic eoe, input logic [23:0] ed);
    repeat (2) @(posedge mclk);
    #1;
    chk(oe_n, eoe);
    chk(fan_duty_out, ed);
  endtask

  task automatic t_reset_values;
    rd(`OTP_IDX_PINCFG, 8'h00);
    rd(`OTP_IDX_ENABLES, 8'h00);
    rd(`OTP_IDX_TEST_A, 8'h00);
    rd(`OTP_IDX_TEST_B, 8'h00);
    rd(`OTP_IDX_TEST_C, 8'h10);
    rd(8'h10, 8'h00);
    wr(`OTP_IDX_TEST_A, 8'hAA);
    wr(`OTP_IDX_TEST_C, 8'h55);
    rd(`OTP_IDX_TEST_A, 8'h00);
    rd(`OTP_IDX_TEST_C, 8'h10);
  endtask

  task automatic t_pin_select;
    for (int k = 0; k < 4; k++) begin
      wr(`OTP_IDX_PINCFG, 8'h20 | k[7:0]);
      #1;
      chk(fn_sel, k[1:0]);
      chk(bypass, 1'b1);
      rd(`OTP_IDX_PINCFG, 8'h20 | k[7:0]);
    end
    wr(`OTP_IDX_ENABLES, 8'h01);
    #1;
    chk(fmt, 1'b1);
    wr(`OTP_IDX_ENABLES, 8'h00);
  endtask

  task automatic t_channels;
    wr(`OTP_IDX_PINCFG, 8'h01);
    wr(`OTP_IDX_LIMIT0, 8'h60);
    wr(`OTP_IDX_LIMIT0 + 8'h01, 8'h60);
    wr(`OTP_IDX_ENABLES, 8'h40);
    temps(8'h70, 8'h70, 8'h00);
    pin(1'b0, 24'hFF_FFFF);
    temps(8'h60, 8'h70, 8'h00);
    pin(1'b1, fan_duty_in);
    wr(`OTP_IDX_ENABLES, 8'h20);
    pin(1'b0, 24'hFF_FFFF);
    wr(`OTP_IDX_ENABLES, 8'h00);
    pin(1'b1, fan_duty_in);
    wr(`OTP_IDX_ENABLES, 8'h20);
    wr(`OTP_IDX_PINCFG, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    chk(oe_n, 1'b1);
    wr(`OTP_IDX_PINCFG, 8'h05);
    pin(1'b1, fan_duty_in);
    wr(`OTP_IDX_PINCFG, 8'h09);
    wr(`OTP_IDX_MAXDUTY0, 8'h11);
    wr(`OTP_IDX_MAXDUTY0 + 8'h01, 8'h22);
    wr(`OTP_IDX_MAXDUTY0 + 8'h02, 8'h33);
    pin(1'b0, 24'h33_2211);
    wr(`OTP_IDX_PINCFG, 8'h01);
    wr(`OTP_IDX_ENABLES, 8'h40);
    wr(`OTP_IDX_LIMIT0, `OTP_OFF64_DISABLED);
    temps(8'hF0, 8'h00, 8'h00);
    pin(1'b1, fan_duty_in);
    wr(`OTP_IDX_ENABLES, 8'h41);
    wr(`OTP_IDX_LIMIT0, `OTP_TWOS_DISABLED);
    temps(8'h10, 8'h00, 8'h00);
    pin(1'b1, fan_duty_in);
    wr(`OTP_IDX_LIMIT0, 8'hF0);
    pin(1'b0, 24'hFF_FFFF);
    temps(8'hE0, 8'h00, 8'h00);
    pin(1'b1, fan_duty_in);
    wr(`OTP_IDX_ENABLES, 8'h00);
  endtask

  task automatic t_latch_irq;
    wr(`OTP_IDX_LIMIT0 + 8'h02, 8'h60);
    wr(`OTP_IDX_MASK, 8'h04);
    wr(`OTP_IDX_STATUS, 8'hFF);
    wr(`OTP_IDX_ENABLES, 8'h80);
    temps(8'h00, 8'h00, 8'h70);
    pin(1'b0, 24'hFF_FFFF);
    chk(irq, 1'b1);
    temps(8'h00, 8'h00, 8'h50);
    pin(1'b0, 24'hFF_FFFF);
    wr(`OTP_IDX_STATUS, 8'h04);
    pin(1'b1, fan_duty_in);
    chk(irq, 1'b0);
    // Remote 1 latches only with the wider latch selection
    wr(`OTP_IDX_PINCFG, 8'h11);
    wr(`OTP_IDX_ENABLES, 8'hA0);
    temps(8'h00, 8'h70, 8'h50);
    pin(1'b0, 24'hFF_FFFF);
    temps(8'h00, 8'h50, 8'h50);
    pin(1'b0, 24'hFF_FFFF);
    wr(`OTP_IDX_STATUS, 8'h02);
    pin(1'b1, fan_duty_in);
    wr(`OTP_IDX_MASK, 8'h00);
    temps(8'h00, 8'h50, 8'h70);
    pin(1'b0, 24'hFF_FFFF);
    chk(irq, 1'b0);
    temps(8'h00, 8'h50, 8'h50);
    wr(`OTP_IDX_STATUS, 8'hFF);
    pin(1'b1, fan_duty_in);
  endtask

  // Someone else pulling the routed pin is the timer input and an event
  task automatic t_ext_pin;
    wr(`OTP_IDX_ENABLES, 8'h00);
    wr(`OTP_IDX_PINCFG, 8'h01);
    wr(`OTP_IDX_STATUS, 8'hFF);
    wr(`OTP_IDX_MASK, 8'h08);
    @(posedge mclk);
    ext_pull <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(timer, 1'b1);
    chk(irq, 1'b1);
    chk(pin_out, 1'b0);
    rd(`OTP_IDX_STATUS, 8'h08);
    @(posedge mclk);
    ext_pull <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(timer, 1'b0);
    wr(`OTP_IDX_STATUS, 8'h08);
    rd(`OTP_IDX_STATUS, 8'h00);
    chk(irq, 1'b0);
    // Routed elsewhere the pin is no timer input
    wr(`OTP_IDX_PINCFG, 8'h00);
    @(posedge mclk);
    ext_pull <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(timer, 1'b0);
    @(posedge mclk);
    ext_pull <= 1'b0;
    wr(`OTP_IDX_MASK, 8'h00);
  endtask

  task automatic t_lock;
    wr(`OTP_IDX_ENABLES, 8'h80);
    wr(`OTP_IDX_PINCFG, 8'h01);
    wr(`OTP_IDX_LOCK, 8'h01);
    wr(`OTP_IDX_ENABLES, 8'hE1);
    wr(`OTP_IDX_PINCFG, 8'h3E);
    rd(`OTP_IDX_ENABLES, 8'h80);
    rd(`OTP_IDX_PINCFG, 8'h01);
  endtask

  task automatic summarize;
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset_values();
    t_pin_select();
    t_channels();
    t_latch_irq();
    t_ext_pin();
    t_lock();
    summarize();
  end

  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    summarize();
  end
endmodule
